/* src/focd_defs.svh */
// constants for the flash overlay command sequencer
`ifndef FOCD_DEFS_SVH
`define FOCD_DEFS_SVH
`define FOCD_OFF_CMD      12'h000
`define FOCD_OFF_ADDR     12'h004
`define FOCD_OFF_WDATA    12'h008
`define FOCD_OFF_STATUS   12'h00C
`define FOCD_OFF_RDATA    12'h010
`define FOCD_CMD_OP_LSB   0
`define FOCD_CMD_OP_W     4
`define FOCD_ST_BUSY_BIT  0
`define FOCD_ST_ABORT_BIT 1
`define FOCD_ST_OVL_LSB   4
`define FOCD_UNLOCK1_ADDR 12'h555
`define FOCD_UNLOCK2_ADDR 12'h2AA
`define FOCD_UNLOCK1_DATA 8'hAA
`define FOCD_UNLOCK2_DATA 8'h55
`define FOCD_CODE_VOL     8'hE0
`define FOCD_CODE_ECC     8'h75
`define FOCD_CODE_PERS    8'hC0
`define FOCD_CODE_PGM     8'hA0
`define FOCD_CODE_ERS     8'h80
`define FOCD_CODE_ERSALL  8'h30
`define FOCD_CODE_EXIT1   8'h90
`define FOCD_CODE_EXIT2   8'h00
`define FOCD_CODE_RESET   8'hF0
`define FOCD_PROT_DATA    8'h00
`define FOCD_UNPROT_DATA  8'h01
`define FOCD_SECT_LSB     16
`define FOCD_PULSE_NS     100
`define FOCD_CLK_NS       50
`define FOCD_PULSE_CYC    ((`FOCD_PULSE_NS + `FOCD_CLK_NS - 1) / `FOCD_CLK_NS)
`endif

/* src/focd_pkg.sv */
// types for the flash overlay command sequencer
package focd_pkg;
  // host orders
  typedef enum logic [3:0] {
    FOCD_OP_READ,
    FOCD_OP_VOL_ENTER,
    FOCD_OP_VOL_LOCK,
    FOCD_OP_VOL_UNLOCK,
    FOCD_OP_ECC_ENTER,
    FOCD_OP_PERS_ENTER,
    FOCD_OP_PERS_PGM,
    FOCD_OP_PERS_ERASE,
    FOCD_OP_EXIT,
    FOCD_OP_RESET,
    FOCD_OP_ABORT_RESET
  } focd_op_type;
  // overlay the device is believed to be in
  typedef enum logic [1:0] {
    FOCD_OVL_ARRAY,
    FOCD_OVL_VOL,
    FOCD_OVL_ECC,
    FOCD_OVL_PERS
  } focd_ovl_type;
endpackage : focd_pkg

/* src/focd_host.sv */
// host controller issuing overlay command sequences to a parallel flash
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "focd_defs.svh"
module focd_host #(
  parameter int AW = 26,                     // flash word address width
  parameter int PW = `FOCD_PULSE_CYC         // strobe low time in cycles
) (
  input  wire logic          i_mclk,         // system clock
  input  wire logic          i_srst,         // synchronous reset
  input  wire logic          i_psel,         // apb select
  input  wire logic          i_penable,      // apb access phase
  input  wire logic          i_pwrite,       // apb direction
  input  wire logic [11:0]   i_paddr,        // apb byte address
  input  wire logic [31:0]   i_pwdata,       // apb write data
  output logic               o_pready,       // apb ready
  output logic [31:0]        o_prdata,       // apb read data
  output logic               o_pslverr,      // apb error
  output logic [AW-1:0]      o_flash_addr,   // flash address pins
  output logic [15:0]        o_flash_dq_o,   // data out
  output logic               o_flash_dq_oe,  // data drive enable
  input  wire logic [15:0]   i_flash_dq_i,   // data in
  output logic               o_flash_ce_n,   // chip enable
  output logic               o_flash_we_n,   // write strobe
  output logic               o_flash_oe_n,   // output enable
  output var focd_pkg::focd_ovl_type o_ovl   // believed overlay
);
  import focd_pkg::*;

  // refuse widths the logic cannot serve: the sector field needs bits above
  // the sector boundary, the address register is loaded from one 32-bit
  // word and the strobe counter is 8 bits wide
  if (AW <= `FOCD_SECT_LSB || AW > 32 || PW < 1 || PW > 256) begin : g_bad_cfg
    $error("focd_host: bad parameters");
  end

  // sequencer states
  typedef enum logic [2:0] {
    FOCD_S_IDLE,
    FOCD_S_SETUP,
    FOCD_S_STROBE,
    FOCD_S_HOLD,
    FOCD_S_NEXT
  } focd_st_type;

  // apb decode
  // a write reaches the order registers only in the access phase; the
  // setup phase alone decides ready, so every transfer takes exactly one
  // access cycle
  wire         apb_acc   = i_psel & i_penable;
  wire         wr_cmd    = apb_acc & i_pwrite & (i_paddr == `FOCD_OFF_CMD);
  wire         wr_addr   = apb_acc & i_pwrite & (i_paddr == `FOCD_OFF_ADDR);
  wire         wr_wdata  = apb_acc & i_pwrite & (i_paddr == `FOCD_OFF_WDATA);
  wire         rd_known  = (i_paddr == `FOCD_OFF_CMD)
                         | (i_paddr == `FOCD_OFF_ADDR)
                         | (i_paddr == `FOCD_OFF_WDATA)
                         | (i_paddr == `FOCD_OFF_STATUS)
                         | (i_paddr == `FOCD_OFF_RDATA);

  focd_st_type  st_q, st_d;                 // sequencer state
  focd_op_type  op_q;                        // order in progress
  focd_ovl_type ovl_q;                       // overlay tracking
  logic [AW-1:0] addr_q;                     // order address
  logic [15:0]  wdata_q;                     // order data
  logic [15:0]  rdata_q;                     // captured read data
  logic [2:0]   step_q;                      // cycle within sequence
  logic [2:0]   nsteps;                      // cycles in this order
  logic [7:0]   cnt_q;                       // strobe width counter
  logic         abort_q;                     // buffer abort seen
  logic         busy_q;                      // sequence running
  logic         cyc_rd;                      // this cycle is a read
  logic [AW-1:0] cyc_addr;                   // this cycle's address
  logic [7:0]   cyc_data;                    // this cycle's command byte
  logic         pready_q;                    // apb ready register
  logic [31:0]  prdata_q;                    // apb read register
  logic         pslverr_q;                   // apb error register

  // unlock prefix shared by all entries
  wire [AW-1:0] ul1 = AW'(`FOCD_UNLOCK1_ADDR);
  wire [AW-1:0] ul2 = AW'(`FOCD_UNLOCK2_ADDR);
  // sector base: low bits cleared, device ignores them anyway
  wire [AW-1:0] sect = {addr_q[AW-1:`FOCD_SECT_LSB],
                        {`FOCD_SECT_LSB{1'b0}}};
  wire          strobe_done = (cnt_q == 8'(PW - 1));
  wire          last_step   = (step_q == nsteps - 3'd1);
  wire          start       = wr_cmd & ~busy_q;

  // cycle table: address, command byte and direction per step
  // each flash cycle walks gap, setup, strobe for PW edges, then hold;
  // ce stays low from setup through hold and address and data only move
  // in the gap, so the device sees them settled on both strobe edges
  // only read, overlay, protection and reset orders exist here: no buffer load
  // and no key programming is ever issued, so word counts, buffer lines
  // and key word order are kept by construction
  always_comb begin
    nsteps   = 3'd1;
    cyc_rd   = 1'b0;
    cyc_addr = '0;
    cyc_data = 8'h00;
    unique case (op_q)
      FOCD_OP_READ: begin                    // plain read
        cyc_rd   = 1'b1;
        cyc_addr = addr_q;
      end
      FOCD_OP_VOL_ENTER, FOCD_OP_ECC_ENTER, FOCD_OP_PERS_ENTER,
      FOCD_OP_ABORT_RESET: begin             // unlock pair
        nsteps   = 3'd3;
        cyc_addr = (step_q == 3'd1) ? ul2 : ul1;
        cyc_data = (step_q == 3'd0) ? `FOCD_UNLOCK1_DATA :
                   (step_q == 3'd1) ? `FOCD_UNLOCK2_DATA :
                   (op_q == FOCD_OP_VOL_ENTER)  ? `FOCD_CODE_VOL :
                   (op_q == FOCD_OP_ECC_ENTER)  ? `FOCD_CODE_ECC :
                   (op_q == FOCD_OP_PERS_ENTER) ? `FOCD_CODE_PERS :
                   `FOCD_CODE_RESET;
      end
      FOCD_OP_VOL_LOCK, FOCD_OP_VOL_UNLOCK, FOCD_OP_PERS_PGM: begin
        nsteps   = 3'd2;
        cyc_addr = (step_q == 3'd0) ? '0 : sect;
        cyc_data = (step_q == 3'd0) ? `FOCD_CODE_PGM :
                   (op_q == FOCD_OP_VOL_UNLOCK) ? `FOCD_UNPROT_DATA :
                   `FOCD_PROT_DATA;
      end
      FOCD_OP_PERS_ERASE: begin
        nsteps   = 3'd2;
        cyc_data = (step_q == 3'd0) ? `FOCD_CODE_ERS : `FOCD_CODE_ERSALL;
      end
      FOCD_OP_EXIT: begin
        nsteps   = (ovl_q == FOCD_OVL_ECC) ? 3'd1 : 3'd2;
        cyc_data = (ovl_q == FOCD_OVL_ECC) ? `FOCD_CODE_RESET :
                   (step_q == 3'd0) ? `FOCD_CODE_EXIT1 : `FOCD_CODE_EXIT2;
      end
      FOCD_OP_RESET: begin
        cyc_data = `FOCD_CODE_RESET;
      end
      default: begin                         // unknown order: one read
        cyc_rd   = 1'b1;
        cyc_addr = addr_q;
      end
    endcase
  end

  // next sequencer state
  // a new order passes through the gap state first, so that op_q and the
  // step count have settled before the setup cycle puts address and data
  // on the pins; going straight to setup would show the previous order's
  // address for one cycle
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      FOCD_S_IDLE:   if (start) st_d = FOCD_S_NEXT;
      FOCD_S_SETUP:  st_d = FOCD_S_STROBE;
      FOCD_S_STROBE: if (strobe_done) st_d = FOCD_S_HOLD;
      FOCD_S_HOLD:   st_d = last_step ? FOCD_S_IDLE : FOCD_S_NEXT;
      FOCD_S_NEXT:   st_d = FOCD_S_SETUP;
    endcase
  end

  // state, step and strobe counter
  // step advances in hold, so the gap state already sees the next step's
  // address and command byte
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_q   <= FOCD_S_IDLE;
      step_q <= 3'd0;
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= (st_q == FOCD_S_STROBE) ? cnt_q + 8'd1 : 8'h00;
      if (start) begin
        busy_q <= 1'b1;
        step_q <= 3'd0;
      end else if (st_q == FOCD_S_HOLD) begin
        busy_q <= ~last_step;
        step_q <= step_q + 3'd1;
      end
    end
  end

  // order registers; writes ignored while busy
  // software cannot change the address or byte under a running sequence;
  // it must poll busy low first
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      op_q    <= FOCD_OP_READ;
      addr_q  <= '0;
      wdata_q <= 16'h0000;
    end else begin
      if (start) op_q <= focd_op_type'(i_pwdata[`FOCD_CMD_OP_W-1:0]);
      if (wr_addr & ~busy_q) addr_q <= i_pwdata[AW-1:0];
      if (wr_wdata & ~busy_q) wdata_q <= i_pwdata[15:0];
    end
  end

  // overlay and abort tracking after each completed order
  // a software abort flag set in the cycle that ends an abort reset wins
  // over the clear, so a fresh abort is never lost
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ovl_q   <= FOCD_OVL_ARRAY;
      abort_q <= 1'b0;
    end else begin
      if (st_q == FOCD_S_HOLD && last_step) begin
        unique case (op_q)
          FOCD_OP_VOL_ENTER:   ovl_q <= FOCD_OVL_VOL;
          FOCD_OP_ECC_ENTER:   ovl_q <= FOCD_OVL_ECC;
          FOCD_OP_PERS_ENTER:  ovl_q <= FOCD_OVL_PERS;
          FOCD_OP_EXIT, FOCD_OP_RESET: ovl_q <= FOCD_OVL_ARRAY;
          FOCD_OP_ABORT_RESET: begin
            ovl_q   <= FOCD_OVL_ARRAY;
            abort_q <= 1'b0;
          end
          default: ovl_q <= ovl_q;
        endcase
      end
      if (wr_wdata & i_pwdata[16]) begin
        abort_q <= 1'b1;                      // software flags an abort
      end
    end
  end

  // flash pins, all registered
  // every strobe and enable comes from a flop fed by the next state, so the
  // strobes carry no combinational glitches towards the device and change
  // with the state; address and data follow the step one cycle late
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_flash_addr  <= '0;
      o_flash_dq_o  <= 16'h0000;
      o_flash_dq_oe <= 1'b0;
      o_flash_ce_n  <= 1'b1;
      o_flash_we_n  <= 1'b1;
      o_flash_oe_n  <= 1'b1;
      rdata_q       <= 16'h0000;
    end else begin
      o_flash_ce_n  <= ~(st_d == FOCD_S_SETUP || st_d == FOCD_S_STROBE
                         || st_d == FOCD_S_HOLD);
      o_flash_we_n  <= ~(st_d == FOCD_S_STROBE && !cyc_rd);
      o_flash_oe_n  <= ~(st_d == FOCD_S_STROBE && cyc_rd);
      // data stays driven through the hold cycle: the device takes the
      // command byte on the rising write strobe, so releasing the bus on
      // that same edge would leave the byte it latches undefined
      o_flash_dq_oe <= (st_d == FOCD_S_SETUP || st_d == FOCD_S_STROBE
                        || st_d == FOCD_S_HOLD) && !cyc_rd;
      o_flash_addr  <= cyc_addr;
      // upper byte zero for command bytes
      o_flash_dq_o  <= {8'h00, cyc_data};
      if (st_q == FOCD_S_STROBE && strobe_done && cyc_rd) begin
        rdata_q <= i_flash_dq_i;
      end
    end
  end

  // apb answers in the access cycle's next edge
  // ready is a one-cycle pulse raised by the setup phase; read data and
  // the error flag come from the address seen in that setup phase, which
  // the master holds through the access phase
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= i_psel & ~i_penable;
      pslverr_q <= i_psel & ~i_penable & ~rd_known;
      unique case (i_paddr)
        `FOCD_OFF_CMD:    prdata_q <= {28'h0, op_q};
        `FOCD_OFF_ADDR:   prdata_q <= 32'(addr_q);
        `FOCD_OFF_WDATA:  prdata_q <= {15'h0, abort_q, wdata_q};
        `FOCD_OFF_STATUS: prdata_q <= {26'h0, ovl_q, 2'b00,
                                       abort_q, busy_q};
        `FOCD_OFF_RDATA:  prdata_q <= {16'h0, rdata_q};
        default:          prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign o_pready  = pready_q;
  assign o_prdata  = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_ovl     = ovl_q;
endmodule // focd_host
`default_nettype wire

/* tb/focd_host_assertions.sv */
// port checks for the overlay command sequencer
`timescale 1ns/10ps
`default_nettype none
module focd_host_assertions #(
  parameter int PW = 2                 // strobe low time in cycles
) (
  input wire logic        i_mclk,
  input wire logic        i_srst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_flash_dq_oe,
  input wire logic        o_flash_ce_n,
  input wire logic        o_flash_we_n,
  input wire logic        o_flash_oe_n
);
  logic [7:0] low_q;                   // edges seen with write strobe low
  logic [7:0] low_d;
  // count restarts whenever the strobe is high
  assign low_d = o_flash_we_n ? 8'h00 : low_q + 8'h01;
  always_ff @(posedge i_mclk) low_q <= i_srst ? 8'h00 : low_d;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence setup_s; i_psel && !i_penable; endsequence
  sequence access_s; i_psel && i_penable && o_pready; endsequence
  chk_answer_next: assert property (setup_s |=> access_s)
    else $error("no ready in first access cycle");
  chk_ready_pulse: assert property (access_s |=> !o_pready)
    else $error("ready held too long");
  chk_ready_cause: assert property (o_pready |-> $past(i_psel) && i_penable)
    else $error("ready without access");
  chk_err_unmapped: assert property (
    o_pready |-> o_pslverr == !(i_paddr inside {12'h000, 12'h004, 12'h008,
                                               12'h00C, 12'h010}))
    else $error("error flag wrong for address");
  chk_write_drive: assert property (
    !o_flash_we_n |-> o_flash_oe_n && o_flash_dq_oe)
    else $error("write cycle without driven data");
  chk_read_float: assert property (!o_flash_oe_n |-> !o_flash_dq_oe)
    else $error("data driven during read");
  chk_strobe_select: assert property (
    !o_flash_we_n || !o_flash_oe_n |-> !o_flash_ce_n)
    else $error("strobe without chip enable");
  chk_setup_first: assert property (
    $fell(o_flash_ce_n) |-> o_flash_we_n && o_flash_oe_n)
    else $error("no setup cycle before strobe");
  chk_data_hold: assert property ($rose(o_flash_we_n) |-> o_flash_dq_oe)
    else $error("data released on write strobe edge");
  chk_pulse_width: assert property ($rose(o_flash_we_n) |-> low_q == PW)
    else $error("write strobe width wrong");
endmodule // focd_host_assertions
bind focd_host focd_host_assertions #(.PW(PW)) chk_i (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_flash_dq_oe(o_flash_dq_oe), .o_flash_ce_n(o_flash_ce_n),
  .o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n));
`default_nettype wire

/* tb/focd_flash_model.sv */
// behavioural parallel flash device decoding overlay commands
`timescale 1ns/10ps
`default_nettype none
module focd_flash_model (
  input  wire logic [25:0] i_addr,    // address pins
  input  wire logic [15:0] i_dq,      // resolved data bus
  input  wire logic        i_ce_n,    // chip enable
  input  wire logic        i_we_n,    // write strobe
  input  wire logic        i_oe_n,    // output enable
  input  wire logic        i_abort,   // bench forces buffer abort state
  output logic      [15:0] o_dq,      // data towards host
  output logic      [1:0]  o_ovl,     // overlay entered
  output var int           o_writes,  // write cycles seen
  output logic             o_abort    // abort state
);
  logic [1023:0] vol_q = '1;          // 1 = unprotected
  logic [1023:0] per_q = '1;
  logic [1:0] st = 0, s;              // unlock progress
  logic [7:0] pend = 0, p;            // setup code awaiting its second cycle
  logic [15:0] last = 0, val;
  wire [9:0] sec = i_addr[25:16];
  wire [10:0] lo = i_addr[10:0];
  wire [7:0] cd = i_dq[7:0];
  wire rd = !i_ce_n && !i_oe_n;
  initial begin
    o_ovl = 0;
    o_writes = 0;
    o_abort = 0;
  end
  always @(posedge i_abort) o_abort = 1'b1;
  // every write-strobe cycle is a command cycle
  always @(posedge i_we_n) if (!i_ce_n) begin
    o_writes++;
    p = pend;
    pend = 0;
    s = st;
    st = 0;
    if (p == 8'hA0 && o_ovl == 1) vol_q[sec] = cd[0];
    else if (p == 8'hA0 && o_ovl == 3) per_q[sec] = 1'b0;
    else if (p == 8'h80) begin if (cd == 8'h30) per_q = '1; end
    else if (p == 8'h90) begin if (cd == 8'h00) o_ovl = 0; end
    else if (s == 2 && lo == 11'h555) begin
      if (cd == 8'hF0) o_abort = 1'b0;
      else if (!o_abort) o_ovl = cd == 8'hE0 ? 2'd1 : cd == 8'h75 ? 2'd2
        : cd == 8'hC0 ? 2'd3 : o_ovl;
    end
    else if (s == 1 && lo == 11'h2AA && cd == 8'h55) st = 2;
    else if (lo == 11'h555 && cd == 8'hAA) st = 1;
    else if (o_abort) st = 0;
    else if (cd == 8'hF0) o_ovl = 0;
    else if (o_ovl != 0) pend = cd;
  end
  // read data by overlay; a released bus shows the inverse of the last word
  assign val = o_ovl == 1 ? {15'h0, vol_q[sec]} : o_ovl == 3 ? {15'h0, per_q[sec]}
    : o_ovl == 2 ? {12'h0, i_addr[3:0]} : i_addr[15:0] ^ 16'h5A5A;
  always @* if (rd) last = val;
  assign o_dq = rd ? val : ~last;
endmodule // focd_flash_model
`default_nettype wire

/* tb/focd_host_tb.sv */
// self-checking bench for the overlay command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "focd_defs.svh"
module focd_host_tb;
  import focd_pkg::*;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, abort_set = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, dq_oe, ce_n, we_n, oe_n, err, m_abort;
  logic [25:0] faddr;
  logic [15:0] dq_o, m_dq, bus;
  logic [1:0] m_ovl;
  focd_ovl_type ovl;
  int m_wr, w0, bad_count = 0, n_tests = 0;
  assign bus = dq_oe ? dq_o : m_dq;   // host owns the bus only while enabled
  always #25 mclk = ~mclk;
  focd_host uut (.i_mclk(mclk), .i_srst(srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .o_flash_addr(faddr), .o_flash_dq_o(dq_o), .o_flash_dq_oe(dq_oe),
    .i_flash_dq_i(bus), .o_flash_ce_n(ce_n), .o_flash_we_n(we_n),
    .o_flash_oe_n(oe_n), .o_ovl(ovl));
  focd_flash_model flash (.i_addr(faddr), .i_dq(bus), .i_ce_n(ce_n),
    .i_we_n(we_n), .i_oe_n(oe_n), .i_abort(abort_set), .o_dq(m_dq),
    .o_ovl(m_ovl), .o_writes(m_wr), .o_abort(m_abort));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // one apb transfer, entered just after a clock edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      $display("unexpected at %0t: no ready", $time);
      bad_count++;
      report_and_stop;
    end
    @(posedge mclk);
  endtask
  // address, data, order, then poll busy under a bound
  task automatic op(input focd_op_type c, input logic [25:0] a, input logic [15:0] d);
    int n;
    w0 = m_wr;
    apb(1, `FOCD_OFF_ADDR, {6'h0, a});
    apb(1, `FOCD_OFF_WDATA, {16'h0, d});
    apb(1, `FOCD_OFF_CMD, {28'h0, c});
    n = 0;
    do begin apb(0, `FOCD_OFF_STATUS, '0); n++; end
    while (r[`FOCD_ST_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) begin
      $display("unexpected at %0t: stuck busy", $time);
      bad_count++;
      report_and_stop;
    end
  endtask
  task automatic rd(input logic [25:0] a);
    op(FOCD_OP_READ, a, '0);
    apb(0, `FOCD_OFF_RDATA, '0);
  endtask
  task automatic t_array;
    apb(0, 12'h040, '0);
    chk(err, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    rd(26'h2345678);
    chk(r[15:0], 16'h5678 ^ 16'h5A5A);
    chk(m_wr - w0, 0);
    $display("test array done");
  endtask
  task automatic t_vol;
    op(FOCD_OP_VOL_ENTER, 26'h0050000, '0);
    chk(m_wr - w0, 3);
    chk({ovl, m_ovl}, {FOCD_OVL_VOL, FOCD_OVL_VOL});
    op(FOCD_OP_VOL_LOCK, 26'h005FFFF, '0); // low bits set on purpose
    rd(26'h0050000);
    chk(r[15:0], 16'h0000);
    op(FOCD_OP_VOL_UNLOCK, 26'h005ABCD, '0);
    rd(26'h0050000);
    chk(r[15:0], 16'h0001);
    op(FOCD_OP_EXIT, '0, '0);
    chk(m_wr - w0, 2);
    chk({ovl, m_ovl}, 4'h0);
    $display("test volatile done");
  endtask
  task automatic t_ecc;
    op(FOCD_OP_ECC_ENTER, '0, '0);
    chk({ovl, m_ovl}, {FOCD_OVL_ECC, FOCD_OVL_ECC});
    rd(26'h0000007);
    chk(r[15:0], 16'h0007);
    op(FOCD_OP_EXIT, '0, '0);
    chk(m_wr - w0, 1);
    chk({ovl, m_ovl}, 4'h0);
    $display("test correction done");
  endtask
  task automatic t_pers;
    op(FOCD_OP_PERS_ENTER, '0, '0);
    chk({ovl, m_ovl}, {FOCD_OVL_PERS, FOCD_OVL_PERS});
    op(FOCD_OP_PERS_PGM, 26'h0031234, '0);
    rd(26'h0030000);
    chk(r[15:0], 16'h0000);
    op(FOCD_OP_PERS_ERASE, '0, '0);
    chk(m_wr - w0, 2);
    rd(26'h0030000);
    chk(r[15:0], 16'h0001);
    op(FOCD_OP_RESET, '0, '0);
    chk(m_wr - w0, 1);
    chk({ovl, m_ovl}, 4'h0);
    $display("test persistent done");
  endtask
  task automatic t_abort;
    apb(1, `FOCD_OFF_WDATA, 32'h0001_0000);
    abort_set <= 1;
    apb(0, `FOCD_OFF_STATUS, '0);
    chk(r[`FOCD_ST_ABORT_BIT], 1'b1);
    op(FOCD_OP_ABORT_RESET, '0, '0);
    chk(m_wr - w0, 3);
    chk({m_abort, r[`FOCD_ST_ABORT_BIT]}, 2'b00);
    $display("test abort done");
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 0;
    t_array;
    t_vol;
    t_ecc;
    t_pers;
    t_abort;
    report_and_stop;
  end
endmodule // focd_host_tb
`default_nettype wire
